// [rtl/iaps_pkg.sv]
package iaps_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_NS     = 5;
   localparam int ERASE0_NS  = 3200000;
   localparam int WRITE0_NS  = 2200000;
   localparam int ERASE1_NS  = 3700000;
   localparam int WRITE1_NS  = 3000000;
   localparam int READ_CYC   = 3;
   localparam int UNLOCK_DEF = 512;
   localparam int CNT_W      = 24;

   // ----------------------------------------------------------------
   // Geometry and codes
   // ----------------------------------------------------------------
   localparam int ADDR_W     = 14;
   localparam int OFF_W      = 5;
   localparam int PAGE_WORDS = 32;
   localparam logic [2:0] MODE_WRITE  = 3'h0;
   localparam logic [2:0] MODE_ERASE  = 3'h1;
   localparam logic [2:0] MODE_READ   = 3'h3;
   localparam logic [2:0] MODE_UNLOCK = 3'h6;
   localparam logic [4:0] OFF_LAST    = 5'h1F;
   localparam logic [7:0] KEY1L_VAL = 8'h00;
   localparam logic [7:0] KEY2L_VAL = 8'h0D;
   localparam logic [7:0] KEY3L_VAL = 8'hC3;
   localparam logic [7:0] KEY1H_VAL = 8'h04;
   localparam logic [7:0] KEY2H_VAL = 8'h09;
   localparam logic [7:0] KEY3H_VAL = 8'h40;

   // ----------------------------------------------------------------
   // Register map (byte offsets) and bit positions
   // ----------------------------------------------------------------
   localparam logic [11:0] REG_CTRL0  = 12'h000;
   localparam logic [11:0] REG_CTRL2  = 12'h004;
   localparam logic [11:0] REG_ADDRL  = 12'h008;
   localparam logic [11:0] REG_ADDRH  = 12'h00C;
   localparam logic [11:0] REG_DATAL  = 12'h010;
   localparam logic [11:0] REG_DATAH  = 12'h014;
   localparam logic [11:0] REG_KEY1L  = 12'h018;
   localparam logic [11:0] REG_KEY1H  = 12'h01C;
   localparam logic [11:0] REG_KEY2L  = 12'h020;
   localparam logic [11:0] REG_KEY2H  = 12'h024;
   localparam logic [11:0] REG_KEY3L  = 12'h028;
   localparam logic [11:0] REG_KEY3H  = 12'h02C;
   localparam logic [11:0] REG_STATUS = 12'h030;
   localparam int C0_ARM    = 3;
   localparam int C0_EWEN   = 4;
   localparam int C0_RDEN   = 5;
   localparam int C0_RDTRIG = 6;
   localparam int C0_OPTRIG = 7;
   localparam int C2_CLR    = 0;
   localparam int C2_TSEL   = 1;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_ERASE = 4'b0010,
      ST_PROG  = 4'b0100,
      ST_READ  = 4'b1000
   } iaps_state_t;

endpackage

// [rtl/iaps_page_buf.sv]
`timescale 1ns/1ps
module iaps_page_buf #(
   parameter int WORDS = 32,
   parameter int AW    = 5,
   parameter int DW    = 16
) (
   input  wire logic          i_mclk,
   input  wire logic          i_resetn,
   input  wire logic          i_clear,
   input  wire logic          i_wr,
   input  wire logic [AW-1:0] i_waddr,
   input  wire logic [DW-1:0] i_wdata,
   input  wire logic [AW-1:0] i_raddr,
   output logic      [DW-1:0] o_rdata,
   output logic               o_rvalid
);
   logic [DW-1:0]    mem [WORDS];
   logic [WORDS-1:0] valid_reg;
   logic [WORDS-1:0] valid_next;

   // ----------------------------------------------------------------
   // Word store; only the valid bits need a reset value
   // ----------------------------------------------------------------
   always_comb begin
      valid_next = valid_reg;
      if (i_clear) begin
         valid_next = '0;
      end
      if (i_wr) begin
         valid_next[i_waddr] = 1'b1;
      end
   end

   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         valid_reg <= '0;
      end else begin
         valid_reg <= valid_next;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_wr) begin
         mem[i_waddr] <= i_wdata;
      end
   end

   assign o_rdata  = mem[i_raddr];
   assign o_rvalid = valid_reg[i_raddr];

endmodule

// [rtl/iaps_top.sv]
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ps
// How it works
// (RULE1) Unlock is recognised only while mode field holds 110.
// (RULE2) Setting the arm bit starts a timer bounding the key window.
// (RULE3) Software writes 00H, 0DH, C3H into the three low key registers.
// (RULE4) Software writes 04H, 09H, 40H into the three high key registers.
// (RULE5) On timer expiry hardware clears the arm bit, whatever the key.
// (RULE6) Full key match sets erase/write enable; wrong key leaves it off.
// (RULE7) Software clears the enable flag directly, no key needed.
// (RULE8) Buffer holds 32 sixteen-bit words; page from address bits 13..5.
// (RULE9) High data byte write loads the word and bumps the address.
// (RULE10) At the last page word the address no longer increments.
// (RULE11) Mode 001 plus trigger erases the page; trigger clears at end.
// (RULE12) Mode 000 plus trigger programs the buffer; trigger clears at end.
// (RULE13) Buffer-clear bit empties the write buffer.
// (RULE14) CPU is stalled while erase, write or read runs.
// (RULE15) Timing-select bit chooses how long the trigger stays high.
// (RULE16) Erase always removes a whole page.
// (RULE17) Write sends the whole buffer as one page.
// (RULE18) Reprogramming a page after clear and reload needs no erase.
// (RULE19) No erase or write while the enable flag is low.
// (RULE20) Mode 011, read enable, read trigger: data lands in data regs.
// (RULE21) Read trigger falls three cycles after it is set.
// (RULE22) Reads need no unlock.
// (RULE23) Software should run the system clock at full speed.
// (RULE24) Select 0: 3.2ms erase, 2.2ms write; 1: 3.7ms, 3.0ms.
// (RULE25) Buffer-clear bit is cleared by hardware when clearing ends.
// (RULE26) Dummy high-byte writes tag addresses, stopping at offset 11111b.
// (RULE27) Trigger while disabled or in another mode leaves flash alone.
module iaps_top
   import iaps_pkg::*;
#(
   parameter int UNLOCK_CYC = UNLOCK_DEF,
   parameter int ERASE0_CYC = (ERASE0_NS + CLK_NS - 1) / CLK_NS,
   parameter int WRITE0_CYC = (WRITE0_NS + CLK_NS - 1) / CLK_NS,
   parameter int ERASE1_CYC = (ERASE1_NS + CLK_NS - 1) / CLK_NS,
   parameter int WRITE1_CYC = (WRITE1_NS + CLK_NS - 1) / CLK_NS
) (
   input  wire logic               i_mclk,
   input  wire logic               i_resetn,
   input  wire logic               i_psel,
   input  wire logic               i_penable,
   input  wire logic               i_pwrite,
   input  wire logic [11:0]        i_paddr,
   input  wire logic [31:0]        i_pwdata,
   output logic      [31:0]        o_prdata,
   output logic                    o_pready,
   output logic                    o_pslverr,
   output logic      [ADDR_W-1:0]  o_fl_addr,
   output logic      [15:0]        o_fl_wdata,
   output logic                    o_fl_we,
   output logic                    o_fl_erase,
   output logic                    o_fl_rd,
   input  wire logic [15:0]        i_fl_rdata,
   output logic                    o_cpu_stall
);
   import iaps_pkg::*;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic is_mapped(input logic [11:0] a);
      is_mapped = (a <= REG_STATUS) && (a[1:0] == 2'b00);
   endfunction

   function automatic logic [CNT_W-1:0] last_cnt(input int n);
      last_cnt = CNT_W'(n - 1);
   endfunction

   logic [2:0]        mode_reg,  mode_next;
   logic              arm_reg,   arm_next;
   logic              ewen_reg,  ewen_next;
   logic              rden_reg,  rden_next;
   logic              clr_reg,   clr_next;
   logic              tsel_reg,  tsel_next;
   logic [ADDR_W-1:0] addr_reg,  addr_next;
   logic [7:0]        dlo_reg,   dlo_next;
   logic [7:0]        dhi_reg,   dhi_next;
   logic [7:0]        key_reg  [6];
   logic [7:0]        key_next [6];
   logic [5:0]        kmask_reg, kmask_next;
   logic [CNT_W-1:0]  ut_reg,    ut_next;
   logic [31:0]       prdata_reg, prdata_next;
   logic              buf_wr;
   logic              start_erase, start_prog, start_rd;
   logic              key_ok;
   logic              wr_acc;
   logic [2:0]        wmode;

   iaps_state_t       state_reg, state_next;
   logic [CNT_W-1:0]  cnt_reg,   cnt_next;
   logic [5:0]        idx_reg,   idx_next;
   logic [ADDR_W-1:0] fla_reg,   fla_next;
   logic [15:0]       flw_reg,   flw_next;
   logic              we_reg,    we_next;
   logic              er_reg,    er_next;
   logic              rd_reg,    rd_next;
   logic [CNT_W-1:0]  op_last;
   logic              rd_done;
   logic              idle;
   logic [15:0]       buf_rdata;
   logic              buf_rvalid;

   // ----------------------------------------------------------------
   // Page buffer
   // ----------------------------------------------------------------
   iaps_page_buf #(
      .WORDS (PAGE_WORDS),
      .AW    (OFF_W),
      .DW    (16)
   ) u_buf (
      .i_mclk   (i_mclk),
      .i_resetn (i_resetn),
      .i_clear  (clr_reg),                               // RULE13
      .i_wr     (buf_wr),
      .i_waddr  (addr_reg[OFF_W-1:0]),                   // RULE8
      .i_wdata  ({i_pwdata[7:0], dlo_reg}),
      .i_raddr  (idx_reg[OFF_W-1:0]),
      .o_rdata  (buf_rdata),
      .o_rvalid (buf_rvalid)
   );

   assign idle     = (state_reg == ST_IDLE);
   assign wr_acc   = i_psel && i_penable && i_pwrite && idle;
   assign wmode    = i_pwdata[2:0];
   assign key_ok   = (key_reg[0] == KEY1L_VAL) && (key_reg[1] == KEY1H_VAL)
                  && (key_reg[2] == KEY2L_VAL) && (key_reg[3] == KEY2H_VAL)
                  && (key_reg[4] == KEY3L_VAL) && (key_reg[5] == KEY3H_VAL);
   assign o_pready  = 1'b1;
   assign o_pslverr = i_psel && i_penable && !is_mapped(i_paddr);
   assign o_prdata  = prdata_reg;
   assign o_cpu_stall = !idle;                           // RULE14

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   always_comb begin
      mode_next   = mode_reg;
      arm_next    = arm_reg;
      ewen_next   = ewen_reg;
      rden_next   = rden_reg;
      clr_next    = 1'b0;                                // RULE25
      tsel_next   = tsel_reg;
      addr_next   = addr_reg;
      dlo_next    = dlo_reg;
      dhi_next    = dhi_reg;
      key_next    = key_reg;
      kmask_next  = kmask_reg;
      ut_next     = ut_reg;
      buf_wr      = 1'b0;
      start_erase = 1'b0;
      start_prog  = 1'b0;
      start_rd    = 1'b0;
      prdata_next = prdata_reg;
      // Key window timer; expiry drops the arm bit regardless of key
      if (arm_reg) begin
         if (ut_reg == last_cnt(UNLOCK_CYC)) begin
            arm_next = 1'b0;                             // RULE5
            ut_next  = '0;
         end else begin
            ut_next = ut_reg + 1'b1;                     // RULE2
         end
      end
      if (rd_done) begin
         dlo_next = i_fl_rdata[7:0];                     // RULE20
         dhi_next = i_fl_rdata[15:8];
      end
      if (wr_acc) begin
         case (i_paddr)
            REG_CTRL0: begin
               mode_next = wmode;
               rden_next = i_pwdata[C0_RDEN];
               if (!i_pwdata[C0_EWEN]) begin
                  ewen_next = 1'b0;                      // RULE7
               end
               if (i_pwdata[C0_ARM] && wmode == MODE_UNLOCK) begin
                  arm_next   = 1'b1;                     // RULE1
                  ut_next    = '0;
                  kmask_next = '0;
               end
               if (i_pwdata[C0_OPTRIG] && ewen_reg) begin
                  start_erase = (wmode == MODE_ERASE);   // RULE19
                  start_prog  = (wmode == MODE_WRITE);   // RULE27
               end
               if (i_pwdata[C0_RDTRIG] && i_pwdata[C0_RDEN]
                   && wmode == MODE_READ) begin
                  start_rd = 1'b1;                       // RULE22
               end
            end
            REG_CTRL2: begin
               clr_next  = i_pwdata[C2_CLR];
               tsel_next = i_pwdata[C2_TSEL];
            end
            REG_ADDRL: addr_next[7:0] = i_pwdata[7:0];
            REG_ADDRH: addr_next[ADDR_W-1:8] = i_pwdata[ADDR_W-9:0];
            REG_DATAL: dlo_next = i_pwdata[7:0];
            REG_DATAH: begin
               dhi_next = i_pwdata[7:0];
               buf_wr   = 1'b1;                          // RULE9
               if (addr_reg[OFF_W-1:0] != OFF_LAST) begin
                  addr_next[OFF_W-1:0] = addr_reg[OFF_W-1:0] + 1'b1;
               end                                       // RULE10 RULE26
            end
            REG_KEY1L, REG_KEY1H, REG_KEY2L,
            REG_KEY2H, REG_KEY3L, REG_KEY3H: begin
               key_next[3'(i_paddr[5:2] - 4'h6)]   = i_pwdata[7:0];
               kmask_next[3'(i_paddr[5:2] - 4'h6)] = 1'b1;
            end
            default: begin
            end
         endcase
      end
      // Hardware set of the enable wins over a same-cycle software clear
      if (arm_reg && mode_reg == MODE_UNLOCK && &kmask_reg && key_ok) begin
         ewen_next = 1'b1;                               // RULE6
      end
      if (i_psel && !i_penable) begin
         case (i_paddr)
            REG_CTRL0:  prdata_next = {24'h0, !idle && state_reg != ST_READ,
                                       state_reg == ST_READ, rden_reg,
                                       ewen_reg, arm_reg, mode_reg};
            REG_CTRL2:  prdata_next = {30'h0, tsel_reg, clr_reg};
            REG_ADDRL:  prdata_next = {24'h0, addr_reg[7:0]};
            REG_ADDRH:  prdata_next = {26'h0, addr_reg[ADDR_W-1:8]};
            REG_DATAL:  prdata_next = {24'h0, dlo_reg};
            REG_DATAH:  prdata_next = {24'h0, dhi_reg};
            REG_KEY1L:  prdata_next = {24'h0, key_reg[0]};
            REG_KEY1H:  prdata_next = {24'h0, key_reg[1]};
            REG_KEY2L:  prdata_next = {24'h0, key_reg[2]};
            REG_KEY2H:  prdata_next = {24'h0, key_reg[3]};
            REG_KEY3L:  prdata_next = {24'h0, key_reg[4]};
            REG_KEY3H:  prdata_next = {24'h0, key_reg[5]};
            REG_STATUS: prdata_next = {28'h0, state_reg};
            default:    prdata_next = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         mode_reg   <= MODE_WRITE;
         arm_reg    <= 1'b0;
         ewen_reg   <= 1'b0;
         rden_reg   <= 1'b0;
         clr_reg    <= 1'b0;
         tsel_reg   <= 1'b0;
         addr_reg   <= '0;
         dlo_reg    <= 8'h00;
         dhi_reg    <= 8'h00;
         key_reg    <= '{default: 8'h00};
         kmask_reg  <= '0;
         ut_reg     <= '0;
         prdata_reg <= 32'h0000_0000;
      end else begin
         mode_reg   <= mode_next;
         arm_reg    <= arm_next;
         ewen_reg   <= ewen_next;
         rden_reg   <= rden_next;
         clr_reg    <= clr_next;
         tsel_reg   <= tsel_next;
         addr_reg   <= addr_next;
         dlo_reg    <= dlo_next;
         dhi_reg    <= dhi_next;
         key_reg    <= key_next;
         kmask_reg  <= kmask_next;
         ut_reg     <= ut_next;
         prdata_reg <= prdata_next;
      end
   end

   // ----------------------------------------------------------------
   // Operation sequencer
   // ----------------------------------------------------------------
   // Busy time is fixed by the select bit; software cannot change it
   // mid-operation because all bus writes are ignored while busy
   always_comb begin
      case ({state_reg == ST_ERASE, tsel_reg})
         2'b10:   op_last = last_cnt(ERASE0_CYC);        // RULE24
         2'b11:   op_last = last_cnt(ERASE1_CYC);
         2'b01:   op_last = last_cnt(WRITE1_CYC);        // RULE15
         default: op_last = last_cnt(WRITE0_CYC);
      endcase
   end

   assign rd_done = (state_reg == ST_READ)
                 && (cnt_reg == last_cnt(READ_CYC));     // RULE21

   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg + 1'b1;
      idx_next   = idx_reg;
      fla_next   = fla_reg;
      flw_next   = flw_reg;
      we_next    = 1'b0;
      er_next    = 1'b0;
      rd_next    = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            cnt_next = '0;
            idx_next = '0;
            if (start_erase) begin
               state_next = ST_ERASE;                    // RULE11
               er_next    = 1'b1;
               fla_next   = {addr_reg[ADDR_W-1:OFF_W], {OFF_W{1'b0}}};
            end else if (start_prog) begin
               state_next = ST_PROG;                     // RULE12 RULE18
            end else if (start_rd) begin
               state_next = ST_READ;
               rd_next    = 1'b1;
               fla_next   = addr_reg;
            end
         end
         ST_ERASE: begin
            if (cnt_reg == op_last) begin
               state_next = ST_IDLE;                     // RULE16
            end
         end
         ST_PROG: begin
            // Walk all page slots; only loaded words reach the array
            if (idx_reg < 6'(PAGE_WORDS)) begin
               we_next  = buf_rvalid;                    // RULE17
               fla_next = {addr_reg[ADDR_W-1:OFF_W], idx_reg[OFF_W-1:0]};
               flw_next = buf_rdata;
               idx_next = idx_reg + 1'b1;
            end
            if (cnt_reg == op_last) begin
               state_next = ST_IDLE;
            end
         end
         ST_READ: begin
            if (rd_done) begin
               state_next = ST_IDLE;                     // RULE20
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         state_reg <= ST_IDLE;
         cnt_reg   <= '0;
         idx_reg   <= '0;
         fla_reg   <= '0;
         flw_reg   <= 16'h0000;
         we_reg    <= 1'b0;
         er_reg    <= 1'b0;
         rd_reg    <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         idx_reg   <= idx_next;
         fla_reg   <= fla_next;
         flw_reg   <= flw_next;
         we_reg    <= we_next;
         er_reg    <= er_next;
         rd_reg    <= rd_next;
      end
   end

   assign o_fl_addr  = fla_reg;
   assign o_fl_wdata = flw_reg;
   assign o_fl_we    = we_reg;
   assign o_fl_erase = er_reg;
   assign o_fl_rd    = rd_reg;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_resetn);

   a_unlock_needs_mode: assert property ( // RULE1
      $rose(ewen_reg) |-> $past(mode_reg) == MODE_UNLOCK && $past(arm_reg))
      else $error("enable set outside unlock mode");
   a_arm_expiry: assert property ( // RULE5
      arm_reg && ut_reg == last_cnt(UNLOCK_CYC) && !wr_acc |=> !arm_reg)
      else $error("arm bit survived timer expiry");
   a_key_match: assert property ( // RULE6
      $rose(ewen_reg) |-> $past(key_ok) && $past(&kmask_reg))
      else $error("enable set without full key");
   a_sw_disable: assert property ( // RULE7
      wr_acc && i_paddr == REG_CTRL0 && !i_pwdata[C0_EWEN] && !arm_reg
      |=> !ewen_reg)
      else $error("enable flag not cleared by software");
   a_addr_incr: assert property ( // RULE9
      wr_acc && i_paddr == REG_DATAH && addr_reg[OFF_W-1:0] != OFF_LAST
      |=> addr_reg == $past(addr_reg) + 1'b1)
      else $error("address did not increment");
   a_addr_stop: assert property ( // RULE10
      wr_acc && i_paddr == REG_DATAH && addr_reg[OFF_W-1:0] == OFF_LAST
      |=> $stable(addr_reg))
      else $error("address passed page end");
   a_trig_gated: assert property ( // RULE27
      wr_acc && i_paddr == REG_CTRL0 && !ewen_reg && !i_pwdata[C0_RDTRIG]
      |=> idle && !o_fl_erase && !o_fl_we)
      else $error("operation started while disabled");
   a_read_time: assert property ( // RULE21
      $rose(state_reg == ST_READ) |-> (state_reg == ST_READ)[*3] ##1 idle)
      else $error("read trigger time wrong");
   a_stall_erase: assert property ( // RULE14
      $rose(o_fl_erase) |-> o_cpu_stall[*8])
      else $error("cpu not stalled during erase");
   a_clear_done: assert property ( // RULE25
      clr_reg |=> !clr_reg || $past(wr_acc && i_paddr == REG_CTRL2))
      else $error("buffer clear bit stuck");

   c_unlock: cover property ($rose(ewen_reg));
   c_erase:  cover property ($rose(state_reg == ST_ERASE));
   c_prog:   cover property (o_fl_we ##1 o_fl_we);
   c_read:   cover property (rd_done);

endmodule

// [test/iaps_flash_model.sv]
`timescale 1ns/1ps
module iaps_flash_model
   import iaps_pkg::*;
(
   input  wire logic              i_mclk,
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [15:0]       i_wdata,
   input  wire logic              i_we,
   input  wire logic              i_erase,
   input  wire logic              i_rd,
   output logic      [15:0]       o_rdata
);
   logic [15:0] mem [0:(1<<ADDR_W)-1];
   logic [1:0]  hold;
   int          n_we;
   initial begin
      n_we = 0;
      hold = 2'h0;
      o_rdata = 16'h0000;
      for (int i = 0; i < (1 << ADDR_W); i++) begin
         mem[i] = 16'(i) ^ 16'h5A5A;
      end
   end
   always @(posedge i_mclk) begin
      if (i_we) begin
         mem[i_addr] <= i_wdata;
         n_we <= n_we + 1;
      end
      if (i_erase) begin
         for (int i = 0; i < PAGE_WORDS; i++) begin
            mem[{i_addr[ADDR_W-1:OFF_W], 5'(i)}] <= 16'h0000;
         end
      end
      if (i_rd) begin
         o_rdata <= mem[i_addr];
         hold <= 2'h3;
      end else if (hold != 2'h0) begin
         hold <= hold - 2'h1;
      end else begin
         // Released bus toggles so a stale word is never mistaken for data
         o_rdata <= ~o_rdata;
      end
   end
endmodule

// [test/iap_flash_program_sequencer_test.sv]
`timescale 1ns/1ps
module iap_flash_program_sequencer_test;
   import iaps_pkg::*;
   localparam int UNL = 64, ER0 = 40, WR0 = 40, ER1 = 45, WR1 = 50;
   logic              i_mclk = 0, i_resetn = 0, i_psel = 0;
   logic              i_penable = 0, i_pwrite = 0;
   logic [11:0]       i_paddr = 12'h000;
   logic [31:0]       i_pwdata = 32'h0, o_prdata, r;
   logic              o_pready, o_pslverr, o_fl_we, o_fl_erase;
   logic              o_fl_rd, o_cpu_stall, err;
   logic [ADDR_W-1:0] o_fl_addr;
   logic [15:0]       o_fl_wdata, i_fl_rdata, v;
   int                num_errors = 0, n_tests = 0;
   always #2.5 i_mclk = ~i_mclk;
   iaps_top #(.UNLOCK_CYC(UNL), .ERASE0_CYC(ER0), .WRITE0_CYC(WR0),
      .ERASE1_CYC(ER1), .WRITE1_CYC(WR1)) iaps_top_inst (
      .i_mclk(i_mclk), .i_resetn(i_resetn), .i_psel(i_psel),
      .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
      .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
      .o_pslverr(o_pslverr), .o_fl_addr(o_fl_addr),
      .o_fl_wdata(o_fl_wdata), .o_fl_we(o_fl_we),
      .o_fl_erase(o_fl_erase), .o_fl_rd(o_fl_rd),
      .i_fl_rdata(i_fl_rdata), .o_cpu_stall(o_cpu_stall));
   iaps_flash_model iaps_flash_model_inst (.i_mclk(i_mclk),
      .i_addr(o_fl_addr), .i_wdata(o_fl_wdata), .i_we(o_fl_we),
      .i_erase(o_fl_erase), .i_rd(o_fl_rd), .o_rdata(i_fl_rdata));
   // ---------------------------
   // Shared tasks
   // ---------------------------
   task complete_run;
      if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
         num_errors++;
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge i_mclk);
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_mclk);
      i_penable <= 1'b1;
      k = 0;
      do begin
         @(posedge i_mclk);
         k++;
      end while (o_pready !== 1'b1 && k < 50);
      if (k >= 50) begin
         $display("unexpected at %0t: bus answer timed out", $time);
         num_errors++;
         complete_run;
      end
      r = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask
   // Counts stalled cycles; a stall that never ends stops the run
   task busy(input int exp);
      int c;
      c = 0;
      while (c < 2000) begin
         @(negedge i_mclk);
         if (o_cpu_stall !== 1'b1) break;
         c++;
      end
      chk(c, exp);
      if (c >= 2000) complete_run;
   endtask
   task rdf(input logic [13:0] a);
      apb(1, REG_ADDRL, {24'h0, a[7:0]});
      apb(1, REG_ADDRH, {26'h0, a[13:8]});
      apb(1, REG_CTRL0, 32'h73);
      busy(3);
      apb(0, REG_DATAL, 0);
      v[7:0] = r[7:0];
      apb(0, REG_DATAH, 0);
      v[15:8] = r[7:0];
   endtask
   task unlock(input logic [31:0] last);
      apb(1, REG_CTRL0, 32'h1E);
      apb(1, REG_KEY1L, 32'h00);
      apb(1, REG_KEY2L, 32'h0D);
      apb(1, REG_KEY3L, 32'hC3);
      apb(1, REG_KEY1H, 32'h04);
      apb(1, REG_KEY2H, 32'h09);
      apb(1, REG_KEY3H, last);
      apb(0, REG_CTRL0, 0);
   endtask
   // ---------------------------
   // Scenarios
   // ---------------------------
   task t_basic;
      rdf(14'h123);
      chk(v, 16'h0123 ^ 16'h5A5A);
      apb(0, 12'h034, 0);
      chk({31'h0, err}, 1);
      chk(r, 0);
      apb(1, REG_CTRL0, 32'h18);
      apb(0, REG_CTRL0, 0);
      chk(r[3], 1'b0);
      apb(1, REG_CTRL0, 32'h90);
      busy(0);
      apb(1, REG_CTRL0, 32'h83);
      busy(0);
   endtask
   task t_unlock;
      unlock(32'h41);
      chk(r[4:3], 2'b01);
      repeat (UNL) @(posedge i_mclk);
      apb(0, REG_CTRL0, 0);
      chk(r[4:3], 2'b00);
      unlock(32'h40);
      chk(r[4], 1'b1);
   endtask
   task t_erase;
      apb(1, REG_ADDRL, 32'hA5);
      apb(1, REG_ADDRH, 32'h00);
      apb(1, REG_DATAH, 32'hFF);
      apb(1, REG_CTRL2, 32'h01);
      apb(1, REG_CTRL0, 32'h91);
      busy(ER0);
      apb(0, REG_CTRL0, 0);
      chk(r[7], 1'b0);
      rdf(14'h0A0);
      chk(v, 16'h0000);
      rdf(14'h0BF);
      chk(v, 16'h0000);
      rdf(14'h0C0);
      chk(v, 16'h00C0 ^ 16'h5A5A);
   endtask
   task t_prog;
      apb(1, REG_CTRL2, 32'h03);
      apb(1, REG_ADDRL, 32'hA0);
      for (int i = 0; i <= PAGE_WORDS; i++) begin
         apb(1, REG_DATAL, i);
         apb(1, REG_DATAH, 32'h10);
      end
      apb(0, REG_ADDRL, 0);
      chk(r, 32'hBF);
      apb(1, REG_CTRL0, 32'h90);
      busy(WR1);
      chk(iaps_flash_model_inst.n_we, 32);
      rdf(14'h0A0);
      chk(v, 16'h1000);
      rdf(14'h0BE);
      chk(v, 16'h101E);
      rdf(14'h0BF);
      chk(v, 16'h1020);
   endtask
   task t_retry;
      apb(1, REG_CTRL2, 32'h01);
      apb(0, REG_CTRL2, 0);
      chk(r, 0);
      apb(1, REG_ADDRL, 32'hA3);
      apb(1, REG_DATAL, 32'h77);
      apb(1, REG_DATAH, 32'h66);
      apb(1, REG_CTRL0, 32'h90);
      busy(WR0);
      chk(iaps_flash_model_inst.n_we, 33);
      rdf(14'h0A3);
      chk(v, 16'h6677);
      apb(1, REG_CTRL0, 32'h92);
      busy(0);
      apb(1, REG_CTRL0, 32'h00);
      apb(0, REG_CTRL0, 0);
      chk(r[4], 1'b0);
      apb(1, REG_CTRL0, 32'h80);
      busy(0);
   endtask
   initial begin
      repeat (4) @(posedge i_mclk);
      i_resetn <= 1'b1;
      t_basic;
      t_unlock;
      t_erase;
      t_prog;
      t_retry;
      complete_run;
   end
endmodule
